// [core/mph_mode_select.sv]
// Mode parameter header and block descriptor decoder with Avalon-MM slave.
// Assumes tape position, buffer and command events arrive synchronous to sys_clk.
`timescale 1ns/100ps
module mph_mode_select #(
    parameter int TICK_CYCLES = mph_pkg::DELAY_TICK_CYCLES,
    parameter logic [7:0] DENS_POWER_ON = mph_pkg::DENS_NEWEST
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Tape and buffer status
    input wire logic logical_tape_start,
    input wire logic [7:0] tape_format,
    input wire logic tape_loaded,
    input wire logic [23:0] tape_block_count,
    input wire logic motion_threshold_hit,
    input wire logic unload_button,
    input wire logic buf_pending,
    input wire logic buf_last_block,
    input wire logic tape_last_block,
    // Settings and events toward the drive
    output logic flush_pulse,
    output logic cmd_status_pulse,
    output logic buffered_mode,
    output logic no_disconnect_flag,
    output logic even_boundary_disconnect,
    output logic variable_blocks,
    output logic [23:0] block_length,
    output logic [7:0] write_density,
    output logic [7:0] read_density
);
    import mph_pkg::*;

    function automatic logic full_check_code(input logic [7:0] code);
        full_check_code = (code == DENS_FMT_A) || (code == DENS_FMT_B) ||
                          (code == DENS_NEWEST) || (code == DENS_FMT_D);
    endfunction

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic bus_req;
    logic wr_accept;
    logic rd_capture;
    logic ctrl_wr;
    logic plen_wr;
    logic pdata_wr;
    logic commit_wr;
    logic tcmd_wr;
    logic wdelay_wr;

    assign bus_req = avs_read | avs_write;
    // One wait cycle: write takes effect where waitrequest is seen low
    assign wr_accept = avs_write & ~wait_reg;
    assign rd_capture = avs_read & wait_reg;
    assign ctrl_wr = wr_accept && (avs_address == REG_CTRL);
    assign plen_wr = wr_accept && (avs_address == REG_PLEN);
    assign pdata_wr = wr_accept && (avs_address == REG_PDATA);
    assign commit_wr = wr_accept && (avs_address == REG_COMMIT) && avs_writedata[0];
    assign tcmd_wr = wr_accept && (avs_address == REG_TAPECMD);
    assign wdelay_wr = wr_accept && (avs_address == REG_WDELAY);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= ~(bus_req & wait_reg);
            if (rd_capture) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // ---------------------------------------------------------------
    // Parameter list capture
    // ---------------------------------------------------------------
    logic [7:0] pbyte_reg [DESC_END];
    logic [7:0] plen_reg;
    logic [7:0] pcnt_reg;
    logic page_format_flag_reg;
    logic two_byte_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            plen_reg <= 8'h00;
            pcnt_reg <= 8'h00;
            for (int i = 0; i < DESC_END; i++) begin
                pbyte_reg[i] <= 8'h00;
            end
        end else if (plen_wr) begin
            plen_reg <= avs_writedata[7:0];
            pcnt_reg <= 8'h00;
        end else if (pdata_wr) begin
            // Bytes past the descriptor belong to pages handled elsewhere
            if (pcnt_reg < DESC_END) begin
                pbyte_reg[pcnt_reg[3:0]] <= avs_writedata[7:0];
            end
            if (pcnt_reg != 8'hff) begin
                pcnt_reg <= pcnt_reg + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Validation of header and descriptor
    // ---------------------------------------------------------------
    logic [2:0] f_mode;
    logic [3:0] f_speed;
    logic [7:0] f_bdl;
    logic [7:0] f_dens;
    logic [23:0] f_blen;
    logic has_desc;
    logic pll_err;
    logic field_err;
    logic dens_err;
    logic blen_err;
    logic any_err;
    logic commit_apply;
    logic blen_mid;
    logic blen_misaligned;
    logic [7:0] dens_target;
    logic [7:0] density_reg;

    assign f_mode = pbyte_reg[2][6:4];
    assign f_speed = pbyte_reg[2][3:0];
    assign f_bdl = pbyte_reg[3];
    assign f_dens = pbyte_reg[4];
    assign f_blen = {pbyte_reg[9], pbyte_reg[10], pbyte_reg[11]};
    assign has_desc = (f_bdl == BDL_FULL);
    // Short header, short descriptor or fewer bytes than declared
    assign pll_err = (plen_reg != 8'h00) && ((plen_reg < HDR_BYTES) || (pcnt_reg < plen_reg) ||
                     (has_desc && (plen_reg < DESC_END)));
    assign field_err = (f_mode != MODE_UNBUF && f_mode != MODE_BUF) ||
                       (f_speed != 4'h0) ||
                       (f_bdl != BDL_NONE && f_bdl != BDL_FULL) ||
                       (has_desc && !full_check_code(f_dens) && f_dens != DENS_NEWEST_NOCHK &&
                        f_dens != DENS_NO_CHANGE);
    assign dens_err = has_desc && full_check_code(f_dens) && !logical_tape_start &&
                      (f_dens != density_reg);
    assign blen_err = has_desc && (f_blen > BLK_MAX_DISC);
    assign any_err = pll_err | field_err | dens_err | blen_err;
    assign commit_apply = commit_wr && (plen_reg != 8'h00) && !any_err;
    assign blen_mid = (f_blen > BLK_MAX_NODISC) && (f_blen <= BLK_MAX_DISC);
    assign blen_misaligned = two_byte_reg ? f_blen[0] : (f_blen[1:0] != 2'b00);
    // 00h maps onto the newest format; 7Fh and the checked codes pass through unchanged
    assign dens_target = (f_dens == DENS_NEWEST_NOCHK) ? DENS_NEWEST : f_dens;

    // ---------------------------------------------------------------
    // Active settings
    // ---------------------------------------------------------------
    logic buffered_reg;
    logic nd_reg;
    logic ebd_reg;
    logic [23:0] blen_reg;
    logic var_reg;
    logic [7:0] rd_dens_reg;
    logic [23:0] blkcnt_reg;
    logic check_reg;
    logic [3:0] sense_reg;
    logic [7:0] asc_reg;
    logic nd_set_bad;
    logic dens_load;

    // Setting no-disconnect with a long fixed block is refused
    assign nd_set_bad = ctrl_wr && avs_writedata[CTRL_ND_BIT] && (blen_reg > BLK_MAX_NODISC);
    assign dens_load = commit_apply && has_desc && logical_tape_start &&
                       (full_check_code(f_dens) || f_dens == DENS_NEWEST_NOCHK);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buffered_reg <= 1'b1;
            nd_reg <= 1'b0;
            ebd_reg <= 1'b0;
            two_byte_reg <= 1'b0;
            page_format_flag_reg <= 1'b0;
            blen_reg <= BLK_LEN_DEFAULT;
            var_reg <= 1'b0;
            density_reg <= 8'h00;
            check_reg <= 1'b0;
            sense_reg <= SENSE_NONE;
            asc_reg <= ASC_NONE;
        end else begin
            if (ctrl_wr) begin
                nd_reg <= avs_writedata[CTRL_ND_BIT] & ~nd_set_bad;
                ebd_reg <= avs_writedata[CTRL_EBD_BIT];
                two_byte_reg <= avs_writedata[CTRL_TWO_BYTE_BIT];
                page_format_flag_reg <= avs_writedata[CTRL_PF_BIT];
                check_reg <= nd_set_bad;
                sense_reg <= nd_set_bad ? SENSE_ILLEGAL : SENSE_NONE;
                asc_reg <= nd_set_bad ? ASC_BAD_FIELD : ASC_NONE;
            end
            if (commit_wr) begin
                check_reg <= any_err;
                sense_reg <= any_err ? SENSE_ILLEGAL : SENSE_NONE;
                asc_reg <= pll_err ? ASC_PLL_ERROR : (any_err ? ASC_BAD_FIELD : ASC_NONE);
            end
            if (commit_apply) begin
                buffered_reg <= (f_mode == MODE_BUF);
                if (has_desc) begin
                    blen_reg <= f_blen;
                    var_reg <= ~|f_blen;
                    if (blen_mid) begin
                        nd_reg <= 1'b0;
                    end
                    if (blen_misaligned) begin
                        ebd_reg <= 1'b0;
                    end
                end
            end
            if (dens_load) begin
                density_reg <= dens_target;
            end else if (density_reg == 8'h00) begin
                // Nothing selected yet: adopt the power-on format
                density_reg <= DENS_POWER_ON;
            end
        end
    end

    // Count and recorded format come from the tape, never from the host
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blkcnt_reg <= 24'h000000;
            rd_dens_reg <= 8'h00;
        end else begin
            if (tape_loaded) begin
                blkcnt_reg <= tape_block_count;
            end
            rd_dens_reg <= tape_format;
        end
    end

    // ---------------------------------------------------------------
    // Buffer flush and status timing
    // ---------------------------------------------------------------
    logic [7:0] wdelay_reg;
    logic [15:0] tick_cnt_reg;
    logic [7:0] delay_cnt_reg;
    logic tick;
    logic timer_run;
    logic timer_exp;
    logic [7:0] op_code;
    logic op_flush;
    logic flush_reg;
    logic status_reg;

    assign op_code = avs_writedata[7:0];
    assign op_flush = tcmd_wr && ((op_code == OP_REWIND) || (op_code == OP_SPACE) ||
                      (op_code == OP_ERASE) || (op_code == OP_LOAD_UNLOAD) ||
                      (op_code == OP_WRITE_FM && !avs_writedata[TCMD_IMMED_BIT]) ||
                      (op_code == OP_LOCATE && avs_writedata[TCMD_REVERSE_BIT]));
    // A zero delay keeps the timer idle, so partial buffers stay put
    assign timer_run = buffered_reg && buf_pending && (wdelay_reg != 8'h00);
    assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
    assign timer_exp = timer_run && tick && (delay_cnt_reg == wdelay_reg - 8'h01);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdelay_reg <= 8'h00;
            tick_cnt_reg <= 16'h0000;
            delay_cnt_reg <= 8'h00;
            flush_reg <= 1'b0;
            status_reg <= 1'b0;
        end else begin
            if (wdelay_wr) begin
                wdelay_reg <= avs_writedata[7:0];
            end
            if (!timer_run || buf_last_block || timer_exp) begin
                tick_cnt_reg <= 16'h0000;
                delay_cnt_reg <= 8'h00;
            end else if (tick) begin
                tick_cnt_reg <= 16'h0000;
                delay_cnt_reg <= delay_cnt_reg + 8'h01;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            end
            // Held data leaves the buffer only on these events
            flush_reg <= buffered_reg && (motion_threshold_hit || unload_button ||
                         op_flush || timer_exp);
            status_reg <= buffered_reg ? buf_last_block : tape_last_block;
        end
    end

    // ---------------------------------------------------------------
    // Read mux and outputs
    // ---------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (avs_address)
            REG_CTRL: begin
                rdata_next = {28'h0000000, page_format_flag_reg, two_byte_reg, ebd_reg, nd_reg};
            end
            REG_PLEN: begin
                rdata_next = {16'h0000, pcnt_reg, plen_reg};
            end
            REG_WDELAY: begin
                rdata_next = {24'h000000, wdelay_reg};
            end
            REG_STATUS: begin
                rdata_next = {8'h00, asc_reg, density_reg, sense_reg, check_reg, 2'b00, buffered_reg};
            end
            REG_BLKLEN: begin
                rdata_next = {8'h00, blen_reg};
            end
            REG_BLKCNT: begin
                rdata_next = {8'h00, blkcnt_reg};
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    assign flush_pulse = flush_reg;
    assign cmd_status_pulse = status_reg;
    assign buffered_mode = buffered_reg;
    assign no_disconnect_flag = nd_reg;
    assign even_boundary_disconnect = ebd_reg;
    assign variable_blocks = var_reg;
    assign block_length = blen_reg;
    assign write_density = density_reg;
    assign read_density = rd_dens_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_bus_answer: assert property (bus_req && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("waitrequest not low exactly one cycle");
    a_mode_decode: assert property (commit_apply |=> buffered_reg == $past(f_mode == MODE_BUF))
        else $error("transfer mode not taken from header");
    a_flush_cmd: assert property (op_flush && buffered_reg |=> flush_reg)
        else $error("flush command did not flush");
    a_delay_zero: assert property (wdelay_reg == 8'h00 |=> delay_cnt_reg == 8'h00)
        else $error("zero write delay expired");
    a_status_time: assert property (buffered_reg && buf_last_block |=> status_reg)
        else $error("buffered status late");
    a_blen_reject: assert property (commit_wr && blen_err |=> check_reg && sense_reg == SENSE_ILLEGAL)
        else $error("oversize block length accepted");
    a_nd_clear: assert property (commit_apply && has_desc && blen_mid |=> !nd_reg)
        else $error("no-disconnect not cleared");
    a_ebd_off: assert property (commit_apply && has_desc && blen_misaligned |=> !ebd_reg)
        else $error("even-boundary disconnect kept");
    a_fmt_start: assert property (!logical_tape_start && density_reg != 8'h00 |=> $stable(density_reg))
        else $error("format changed away from tape start");
    a_pll_error: assert property (commit_wr && pll_err |=> asc_reg == ASC_PLL_ERROR && $stable(blen_reg))
        else $error("truncated list not reported");
endmodule

// [pkg/mph_pkg.sv]
// Constants for the mode parameter header and block descriptor decoder.
// Assumes one 40 MHz clock and an Avalon-MM master using word addresses.
//
// Contract
// - Header byte 2 bits 6..4: 000b unbuffered, 001b buffered writing.
// - Buffered mode holds data and marks until a flush event occurs.
// - Rewind, sync filemarks, space, erase, load/unload, reverse locate flush the buffer.
// - Write delay expiry flushes; zero delay never flushes on timeout.
// - Buffered: status when data is buffered; unbuffered: when on tape.
// - Power-on transfer mode is buffered, 001b.
// - Speed field must be zero; speed never changes.
// - Descriptor length is 00h or 08h, one descriptor only.
// - Density 00h selects newest compressed format; ignored silently away from start.
// - Densities 14h, 15h, 8Ch, 90h accepted with full checking.
// - Checked density changing format away from start gives illegal request 5h.
// - Density 7Fh keeps the format and suppresses checking.
// - One format per tape; change only at logical tape start.
// - Reads follow the detected recorded format, not the selection.
// - Blank tape before any selection uses power-on default format.
// - Block count computed at load and reported; supplied count ignored.
// - Block length 0 means variable blocks; nonzero means fixed size.
// - Power-on block length is 400h bytes.
// - Maximum block length 03C000h, or 28000h with no-disconnect set.
// - Block length 28001h..03C000h clears the no-disconnect flag.
// - Block length above 03C000h gives illegal request 5h.
// - Length not multiple of 4 (or 2) disables even-boundary disconnect.
// - Truncated header, descriptor or page gives parameter list length error.
// - No-disconnect flag resets to 0; set forbids disconnect in data transfer.
package mph_pkg;
    // Register word indices (byte address is four times the index)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PLEN = 4'h1;
    localparam logic [3:0] REG_PDATA = 4'h2;
    localparam logic [3:0] REG_COMMIT = 4'h3;
    localparam logic [3:0] REG_TAPECMD = 4'h4;
    localparam logic [3:0] REG_WDELAY = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_BLKLEN = 4'h7;
    localparam logic [3:0] REG_BLKCNT = 4'h8;
    // Control register bits
    localparam int CTRL_ND_BIT = 0;
    localparam int CTRL_EBD_BIT = 1;
    localparam int CTRL_TWO_BYTE_BIT = 2;
    localparam int CTRL_PF_BIT = 3;
    // Tape command register fields
    localparam int TCMD_IMMED_BIT = 8;
    localparam int TCMD_REVERSE_BIT = 9;
    // Parameter list layout
    localparam logic [7:0] HDR_BYTES = 8'h04;
    localparam logic [7:0] DESC_END = 8'h0c;
    localparam logic [2:0] MODE_UNBUF = 3'h0;
    localparam logic [2:0] MODE_BUF = 3'h1;
    localparam logic [7:0] BDL_NONE = 8'h00;
    localparam logic [7:0] BDL_FULL = 8'h08;
    // Density codes
    localparam logic [7:0] DENS_NEWEST_NOCHK = 8'h00;
    localparam logic [7:0] DENS_FMT_A = 8'h14;
    localparam logic [7:0] DENS_FMT_B = 8'h15;
    localparam logic [7:0] DENS_NO_CHANGE = 8'h7f;
    localparam logic [7:0] DENS_NEWEST = 8'h8c;
    localparam logic [7:0] DENS_FMT_D = 8'h90;
    // Block length limits and default
    localparam logic [23:0] BLK_LEN_DEFAULT = 24'h000400;
    localparam logic [23:0] BLK_MAX_DISC = 24'h03c000;
    localparam logic [23:0] BLK_MAX_NODISC = 24'h028000;
    // Sense answers
    localparam logic [3:0] SENSE_NONE = 4'h0;
    localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_PLL_ERROR = 8'h1a;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h26;
    // Opcodes that flush the write buffer (write filemarks only without immed, locate only in reverse)
    localparam logic [7:0] OP_REWIND = 8'h01;
    localparam logic [7:0] OP_WRITE_FM = 8'h10;
    localparam logic [7:0] OP_SPACE = 8'h11;
    localparam logic [7:0] OP_ERASE = 8'h19;
    localparam logic [7:0] OP_LOAD_UNLOAD = 8'h1b;
    localparam logic [7:0] OP_LOCATE = 8'h2b;
    // Write delay time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int DELAY_TICK_NS = 1000000;
    localparam int DELAY_TICK_CYCLES = (DELAY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [test/mph_initiator.sv]
// Avalon-MM master standing in for the initiator that delivers parameter lists.
// Assumes one clock and a slave that stalls through waitrequest.
`timescale 1ns/100ps
module mph_initiator (
    // Clock
    input wire logic sys_clk,
    // Avalon-MM master side
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // Request held until waitrequest is sampled low; no fixed latency assumed
    task automatic access(input logic rw, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= rw;
        avs_read <= !rw;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
endmodule

// [test/mph_mode_select_bench.sv]
// Self-checking bench for the mode parameter decoder.
// Assumes the initiator model owns the register bus; tape events come from here.
`timescale 1ns/100ps
module mph_mode_select_bench;
    import mph_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, st;
    logic tape_start = 1'b1;
    logic buf_pending = 1'b0;
    logic [7:0] tape_format = 8'h00;
    logic [23:0] blk_cnt_in = 24'h000000;
    logic [4:0] ev = 5'h00;
    logic flush_pulse, cmd_status_pulse, buffered_mode, no_disconnect_flag, even_boundary_disconnect, variable_blocks;
    logic [23:0] block_length;
    logic [7:0] write_density, read_density;
    wire logic [3:0] flags = {buffered_mode, no_disconnect_flag, even_boundary_disconnect, variable_blocks};
    localparam logic [12:0] ST_OK = 13'h0000;
    localparam logic [12:0] ST_BAD = {ASC_BAD_FIELD, SENSE_ILLEGAL, 1'b1};
    localparam logic [12:0] ST_PLL = {ASC_PLL_ERROR, SENSE_ILLEGAL, 1'b1};
    int num_errors = 0;
    int total_checks = 0;
    int n_flush = 0;
    int n_stat = 0;
    int exp_f = 0;
    int cycles = 0;
    logic [9:0] ops [8] = '{10'h001, 10'h011, 10'h019, 10'h01b, 10'h010, 10'h22b, 10'h110, 10'h02b};
    int fl [8] = '{1, 1, 1, 1, 1, 1, 0, 0};
    logic [7:0] dens [5] = '{8'h15, 8'h90, 8'h8c, 8'h00, 8'h7f};
    logic [7:0] dexp [5] = '{8'h15, 8'h90, 8'h8c, 8'h8c, 8'h8c};

    // ----------------------------------------
    // Instances
    // ----------------------------------------
    // Short write-delay tick keeps the timer scenario brief
    mph_mode_select #(.TICK_CYCLES(4)) u_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .logical_tape_start(tape_start), .tape_format(tape_format),
        .tape_loaded(ev[0]), .tape_block_count(blk_cnt_in), .motion_threshold_hit(ev[1]), .unload_button(ev[2]),
        .buf_pending(buf_pending), .buf_last_block(ev[3]), .tape_last_block(ev[4]), .flush_pulse(flush_pulse),
        .cmd_status_pulse(cmd_status_pulse), .buffered_mode(buffered_mode), .no_disconnect_flag(no_disconnect_flag),
        .even_boundary_disconnect(even_boundary_disconnect), .variable_blocks(variable_blocks),
        .block_length(block_length), .write_density(write_density), .read_density(read_density));
    mph_initiator u_host (.sys_clk(sys_clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (flush_pulse === 1'b1) n_flush++;
        if (cmd_status_pulse === 1'b1) n_stat++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.access(1'b1, a, d, q);
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        u_host.access(1'b0, a, 32'h0, q);
    endtask
    task automatic stchk(input logic [12:0] e);
        chk("status", {19'h0, st[23:16], st[7:3]}, {19'h0, e});
    endtask
    // Pulse event line i, then n idle cycles
    task automatic hit(input int i, input int n);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev <= 5'h00;
        repeat (n) @(posedge sys_clk);
    endtask
    // Header and descriptor; n < plen truncates; block count is junk
    task automatic send(input logic [7:0] plen, input int n, input logic [7:0] ms, input logic [7:0] bdl,
                        input logic [7:0] dc, input logic [23:0] blen);
        logic [7:0] b [12];
        b = '{8'h00, 8'h00, ms, bdl, dc, 8'h12, 8'h34, 8'h56, 8'h00, blen[23:16], blen[15:8], blen[7:0]};
        wr(REG_PLEN, {24'h0, plen});
        for (int i = 0; i < n; i++) wr(REG_PDATA, {24'h0, b[i]});
        wr(REG_COMMIT, 32'h1);
        rd(REG_STATUS, st);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("flags", 32'(flags), 32'h8);
        chk("blklen", 32'(block_length), 32'h400);
        chk("wdens", 32'(write_density), 32'h8c);
        hit(1, 3);
        hit(2, 3);
        exp_f = 2;
        chk("flush", 32'(n_flush), 32'(exp_f));
        foreach (ops[i]) begin
            wr(REG_TAPECMD, {22'h0, ops[i]});
            repeat (3) @(posedge sys_clk);
            exp_f += fl[i];
            chk("flush", 32'(n_flush), 32'(exp_f));
        end
        wr(REG_WDELAY, 32'h1);
        buf_pending <= 1'b1;
        repeat (12) @(posedge sys_clk);
        buf_pending <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("timer", 32'(n_flush > exp_f), 32'h1);
        exp_f = n_flush;
        wr(REG_WDELAY, 32'h0);
        buf_pending <= 1'b1;
        repeat (40) @(posedge sys_clk);
        buf_pending <= 1'b0;
        chk("timer", 32'(n_flush), 32'(exp_f));
        hit(3, 3);
        hit(4, 3);
        chk("status_pulse", 32'(n_stat), 32'h1);
        blk_cnt_in <= 24'h123456;
        tape_format <= 8'h15;
        hit(0, 2);
        rd(REG_BLKCNT, st);
        chk("blkcnt", st, 32'h123456);
        chk("rdens", 32'(read_density), 32'h15);
        rd(4'hf, st);
        chk("unmapped", st, 32'h0);
        // Unbuffered, variable blocks, legacy format at tape start
        send(8'h0c, 12, 8'h00, BDL_FULL, 8'h14, 24'h0);
        stchk(ST_OK);
        chk("flags", 32'(flags), 32'h1);
        chk("wdens", 32'(write_density), 32'h14);
        rd(REG_BLKCNT, st);
        chk("blkcnt", st, 32'h123456);
        hit(3, 3);
        hit(4, 3);
        hit(1, 3);
        chk("status_pulse", 32'(n_stat), 32'h2);
        chk("flush", 32'(n_flush), 32'(exp_f));
        foreach (dens[i]) begin
            send(8'h0c, 12, 8'h10, BDL_FULL, dens[i], 24'h400);
            stchk(ST_OK);
            chk("wdens", 32'(write_density), 32'(dexp[i]));
        end
        // Away from tape start
        tape_start <= 1'b0;
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h14, 24'h400);
        stchk(ST_BAD);
        chk("wdens", 32'(write_density), 32'h8c);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h00, 24'h400);
        stchk(ST_OK);
        send(8'h0c, 12, 8'h00, BDL_FULL, 8'h7f, 24'h400);
        stchk(ST_OK);
        send(8'h0c, 12, 8'h11, BDL_FULL, 8'h7f, 24'h400);
        stchk(ST_BAD);
        send(8'h0c, 12, 8'h20, BDL_FULL, 8'h7f, 24'h400);
        stchk(ST_BAD);
        send(8'h0c, 12, 8'h10, 8'h04, 8'h7f, 24'h400);
        stchk(ST_BAD);
        send(8'h02, 2, 8'h10, BDL_NONE, 8'h7f, 24'h400);
        stchk(ST_PLL);
        send(8'h0c, 10, 8'h10, BDL_FULL, 8'h7f, 24'h400);
        stchk(ST_PLL);
        chk("flags", 32'(flags), 32'h0);
        // Block length limits against the no-disconnect flag
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h400);
        wr(REG_CTRL, 32'h3);
        chk("flags", 32'(flags), 32'he);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h028001);
        chk("flags", 32'(flags), 32'h8);
        chk("blklen", 32'(block_length), 32'h028001);
        wr(REG_CTRL, 32'h1);
        rd(REG_STATUS, st);
        stchk(ST_BAD);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h03c001);
        stchk(ST_BAD);
        chk("blklen", 32'(block_length), 32'h028001);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h028000);
        wr(REG_CTRL, 32'h3);
        chk("flags", 32'(flags), 32'he);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h03c000);
        stchk(ST_OK);
        chk("flags", 32'(flags), 32'ha);
        wr(REG_CTRL, 32'h6);
        send(8'h0c, 12, 8'h10, BDL_FULL, 8'h7f, 24'h028002);
        chk("flags", 32'(flags), 32'ha);
        results();
    end
endmodule
